/* File: pic_regs.svh */
// Register map, field positions, reset values and vector addresses of the interrupt controller
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PIC_ADDR_SELECT 8'ha6
`define PIC_ADDR_EN_PRI 8'ha8
`define PIC_ADDR_PRIO_LO 8'ha9
`define PIC_ADDR_EN_SEC 8'hb8
`define PIC_ADDR_PRIO_HI 8'hb9
`define PIC_ADDR_FLAGS 8'hc0

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define PIC_RST_SELECT 8'h01
`define PIC_RST_ZERO 8'h00
`define PIC_MASK_SELECT 8'h3f
`define PIC_MASK_EN 8'hbf
`define PIC_MASK_PRIO 8'h3f

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PIC_EN_GLOBAL 7
`define PIC_EN_RELOAD 7
`define PIC_SEL_PIN_LSB 3
`define PIC_SEL_TWO_WIRE 2
`define PIC_SEL_MASTER 1
`define PIC_SEL_SLAVE 0
`define PIC_FLAG_RELOAD 7
`define PIC_FLAG_T3OVF 6
`define PIC_FLAG_AUTO_LSB 2
`define PIC_FLAG_AUTO_MSB 5
`define PIC_FIRST_FLAG_SRC 6
`define PIC_NUM_GROUPS 6
`define PIC_NUM_SRC 12

// ------------------------------------------------------------
// Vector addresses, in source index order
// ------------------------------------------------------------
`define PIC_VEC_PIN 16'h0003
`define PIC_VEC_T1 16'h000b
`define PIC_VEC_POWER 16'h0013
`define PIC_VEC_T2 16'h001b
`define PIC_VEC_SERIAL 16'h0023
`define PIC_VEC_T3 16'h002b
`define PIC_VEC_RADIO_SERIAL_READY 16'h0043
`define PIC_VEC_RADIO 16'h004b
`define PIC_VEC_BUS 16'h0053
`define PIC_VEC_WAKEPIN 16'h005b
`define PIC_VEC_MISC 16'h0063
`define PIC_VEC_TICK 16'h006b

`endif

/* File: pic_pkg.sv */
// Types and shared functions of the interrupt controller
`include "pic_regs.svh"
package pic_pkg;

  typedef logic [1:0] pic_level_t;

  // Request handshake towards the core
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_REQ = 3'b010,
    PIC_HOLD = 3'b100
  } pic_state_e;

  // Special-function-register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pic_sfr_req_s;

  // Peripheral and pin request lines
  typedef struct packed {
    logic firstTimerOverflow;
    logic secondTimerOverflow;
    logic serialReceiveRequest;
    logic serialTransmitRequest;
    logic thirdTimerOverflow;
    logic thirdTimerReload;
    logic powerFailRequestN;
    logic radioSerialReady;
    logic radioRequest;
    logic masterSerialDone;
    logic twoWireDone;
    logic slaveSerialDone;
    logic wakeOnPinRequest;
    logic crystalStartedRequest;
    logic converterReadyRequest;
    logic randomReadyRequest;
    logic wakeTimerTick;
    logic [2:0] gpPinInputN;
  } pic_src_s;

  // Wake-up configuration seen by the controller
  typedef struct packed {
    logic radioEn;
    logic pinEn;
    logic miscEn;
    logic tickEn;
    logic pinPolarity;
  } pic_wake_s;

  // Level of a group from the two priority registers
  function automatic pic_level_t groupLevel(input logic [7:0] hi, input logic [7:0] lo,
                                            input int unsigned grp);
    groupLevel = {hi[grp], lo[grp]};
  endfunction : groupLevel

  // Vector address of a source index
  function automatic logic [15:0] vectorAddr(input logic [3:0] idx);
    case (idx)
      4'h0: vectorAddr = `PIC_VEC_PIN;
      4'h1: vectorAddr = `PIC_VEC_T1;
      4'h2: vectorAddr = `PIC_VEC_POWER;
      4'h3: vectorAddr = `PIC_VEC_T2;
      4'h4: vectorAddr = `PIC_VEC_SERIAL;
      4'h5: vectorAddr = `PIC_VEC_T3;
      4'h6: vectorAddr = `PIC_VEC_RADIO_SERIAL_READY;
      4'h7: vectorAddr = `PIC_VEC_RADIO;
      4'h8: vectorAddr = `PIC_VEC_BUS;
      4'h9: vectorAddr = `PIC_VEC_WAKEPIN;
      4'ha: vectorAddr = `PIC_VEC_MISC;
      default: vectorAddr = `PIC_VEC_TICK;
    endcase
  endfunction : vectorAddr

endpackage : pic_pkg

/* File: pic_edge_detect.sv */
// Per-bit edge detector with selectable rising and falling sensitivity
`timescale 1ns/1ps
module pic_edge_detect #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RISE_MASK = '1,
  parameter logic [WIDTH-1:0] FALL_MASK = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] prev_reg;

  // Previous sample of each line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  // One-cycle pulse on each selected edge
  assign pulse = (level & ~prev_reg & RISE_MASK) | (~level & prev_reg & FALL_MASK);

endmodule : pic_edge_detect

/* File: pic_prio_arbiter.sv */
// Picks the highest-level pending source, lowest index on a tie
`timescale 1ns/1ps
module pic_prio_arbiter #(
  parameter int N = 12
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][1:0] level,
  output logic valid,
  output logic [3:0] idx,
  output logic [1:0] winLevel
);

  // Scan downward so an equal level at a lower index takes over
  always_comb begin
    valid = 1'b0;
    idx = 4'h0;
    winLevel = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!valid || level[i] >= winLevel)) begin
        valid = 1'b1;
        idx = 4'(i);
        winLevel = level[i];
      end
    end
  end

endmodule : pic_prio_arbiter

/* File: pic_top.sv */
// Prioritized interrupt controller: registers, source conditioning and core handshake
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_top (
  input wire logic clk,
  input wire logic rst,
  input wire pic_pkg::pic_sfr_req_s sfrReq,
  output logic [7:0] sfrRdata,
  input wire pic_pkg::pic_src_s src,
  input wire pic_pkg::pic_wake_s wake,
  input wire logic irqAck,
  input wire logic retiPulse,
  output logic irqReq,
  output logic [15:0] irqVector,
  output logic [1:0] irqLevel
);
  import pic_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] select_reg;
  logic [7:0] enPri_reg;
  logic [7:0] enSec_reg;
  logic [7:0] prioLo_reg;
  logic [7:0] prioHi_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flagSet;
  logic [7:0] flagAutoClr;
  logic [3:0] inService_reg;
  logic [3:0] inService_next;
  logic [3:0] irqIdx_reg;
  logic [7:0] sfrRdata_next;
  pic_state_e state_reg;
  pic_state_e state_next;
  logic [2:0] pinSel;
  logic pinSource;
  logic [5:0] edgeLevel;
  logic [5:0] edgePulse;
  logic busEvent;
  logic [`PIC_NUM_SRC-1:0] srcPending;
  logic [`PIC_NUM_SRC-1:0] srcEnable;
  logic [`PIC_NUM_SRC-1:0] srcReq;
  logic [`PIC_NUM_SRC-1:0][1:0] srcLevel;
  logic winValid;
  logic [3:0] winIdx;
  logic [1:0] winLevel;
  logic canPreempt;
  logic [1:0] activeLevel;
  logic anyActive;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------

  // Selection register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      select_reg <= `PIC_RST_SELECT;
    end else if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_SELECT) begin
      select_reg <= sfrReq.wdata & `PIC_MASK_SELECT;
    end
  end

  // Primary and secondary enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enPri_reg <= `PIC_RST_ZERO;
      enSec_reg <= `PIC_RST_ZERO;
    end else begin
      if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_EN_PRI) begin
        enPri_reg <= sfrReq.wdata & `PIC_MASK_EN;
      end
      if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_EN_SEC) begin
        enSec_reg <= sfrReq.wdata & `PIC_MASK_EN;
      end
    end
  end

  // Priority registers, top two bits unused
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prioLo_reg <= `PIC_RST_ZERO;
      prioHi_reg <= `PIC_RST_ZERO;
    end else begin
      if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_PRIO_LO) begin
        prioLo_reg <= sfrReq.wdata & `PIC_MASK_PRIO;
      end
      if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_PRIO_HI) begin
        prioHi_reg <= sfrReq.wdata & `PIC_MASK_PRIO;
      end
    end
  end

  // ------------------------------------------------------------
  // Source conditioning
  // ------------------------------------------------------------

  // Only the lowest selected pin is routed, so two selections never merge
  always_comb begin
    pinSel = 3'h0;
    if (select_reg[`PIC_SEL_PIN_LSB]) begin
      pinSel = 3'h1;
    end else if (select_reg[`PIC_SEL_PIN_LSB+1]) begin
      pinSel = 3'h2;
    end else if (select_reg[`PIC_SEL_PIN_LSB+2]) begin
      pinSel = 3'h4;
    end
  end

  assign pinSource = |(~src.gpPinInputN & pinSel);

  // Edge lines: bus completions, radio, wake pin, miscellaneous, tick
  always_comb begin
    // bus completion lines gated by selection bits
    edgeLevel[0] = src.twoWireDone & select_reg[`PIC_SEL_TWO_WIRE];
    edgeLevel[1] = src.masterSerialDone & select_reg[`PIC_SEL_MASTER];
    edgeLevel[2] = src.slaveSerialDone & select_reg[`PIC_SEL_SLAVE];
    // wake-up enables let these sources through
    edgeLevel[3] = src.radioRequest & wake.radioEn;
    // pin polarity folded so the line always rises
    edgeLevel[4] = (src.wakeOnPinRequest ^ wake.pinPolarity) & wake.pinEn;
    edgeLevel[5] = (src.crystalStartedRequest | src.converterReadyRequest |
                    src.randomReadyRequest) & wake.miscEn;
  end

  // Bus and radio take either edge; wake pin and miscellaneous rise only
  pic_edge_detect #(
    .WIDTH(6),
    .RISE_MASK(6'h3f),
    .FALL_MASK(6'h0f)
  ) u_edges (
    .clk(clk),
    .rst(rst),
    .level(edgeLevel),
    .pulse(edgePulse)
  );

  logic tickPulse;

  pic_edge_detect #(
    .WIDTH(1),
    .RISE_MASK(1'b1),
    .FALL_MASK(1'b0)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .level(src.wakeTimerTick & wake.tickEn),
    .pulse(tickPulse)
  );

  assign busEvent = |edgePulse[2:0];

  // ------------------------------------------------------------
  // Request flag register
  // ------------------------------------------------------------

  // Hardware set events, bit per flag
  always_comb begin
    flagSet = {src.thirdTimerReload, src.thirdTimerOverflow, tickPulse, edgePulse[5],
               edgePulse[4], busEvent, edgePulse[3], src.radioSerialReady};
  end

  // Flags 5..2 clear when the core enters their handler
  always_comb begin
    flagAutoClr = 8'h00;
    if (irqAck && state_reg == PIC_REQ && irqIdx_reg >= 4'(`PIC_FIRST_FLAG_SRC)) begin
      flagAutoClr[3'(irqIdx_reg - 4'(`PIC_FIRST_FLAG_SRC))] = 1'b1;
    end
    flagAutoClr[`PIC_FLAG_RELOAD] = 1'b0;
    flagAutoClr[`PIC_FLAG_T3OVF] = 1'b0;
    flagAutoClr[1] = 1'b0;
    flagAutoClr[0] = 1'b0;
  end

  // Software write or auto clear, but a set in the same cycle wins
  always_comb begin
    flags_next = flags_reg & ~flagAutoClr;
    if (sfrReq.wr && sfrReq.addr == `PIC_ADDR_FLAGS) begin
      flags_next = sfrReq.wdata;
    end
    flags_next = flags_next | flagSet;
  end

  // Flag storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= `PIC_RST_ZERO;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ------------------------------------------------------------
  // Pending, enable and level per source
  // ------------------------------------------------------------

  // Pending state in vector order
  always_comb begin
    // timers active high, power failure active low
    srcPending[0] = pinSource;
    srcPending[1] = src.firstTimerOverflow;
    srcPending[2] = ~src.powerFailRequestN;
    srcPending[3] = src.secondTimerOverflow;
    srcPending[4] = src.serialReceiveRequest | src.serialTransmitRequest;
    srcPending[5] = flags_reg[`PIC_FLAG_T3OVF] |
                    (flags_reg[`PIC_FLAG_RELOAD] & enSec_reg[`PIC_EN_RELOAD]);
    srcPending[11:6] = flags_reg[5:0];
  end

  assign srcEnable = {enSec_reg[5:0], enPri_reg[5:0]};

  assign srcReq = enPri_reg[`PIC_EN_GLOBAL] ? (srcPending & srcEnable) : '0;

  // Level of each source from its group
  always_comb begin
    for (int i = 0; i < `PIC_NUM_SRC; i++) begin
      srcLevel[i] = groupLevel(prioHi_reg, prioLo_reg, i % `PIC_NUM_GROUPS);
    end
  end

  pic_prio_arbiter #(
    .N(`PIC_NUM_SRC)
  ) u_arb (
    .req(srcReq),
    .level(srcLevel),
    .valid(winValid),
    .idx(winIdx),
    .winLevel(winLevel)
  );

  // ------------------------------------------------------------
  // In-service levels and core handshake
  // ------------------------------------------------------------

  // Highest level currently in service
  always_comb begin
    anyActive = |inService_reg;
    activeLevel = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (inService_reg[l]) begin
        activeLevel = 2'(l);
      end
    end
  end

  // only a strictly higher level preempts
  assign canPreempt = winValid && (!anyActive || winLevel > activeLevel);

  // In-service tracking
  always_comb begin
    inService_next = inService_reg;
    if (retiPulse && anyActive) begin
      inService_next[activeLevel] = 1'b0;
    end
    if (irqAck && state_reg == PIC_REQ) begin
      inService_next[irqLevel] = 1'b1;
    end
  end

  // Handshake: present, then hold one cycle after entry for state to settle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PIC_IDLE: begin
        if (canPreempt) begin
          state_next = PIC_REQ;
        end
      end
      PIC_REQ: begin
        if (irqAck) begin
          state_next = PIC_HOLD;
        end else if (!canPreempt) begin
          state_next = PIC_IDLE;
        end
      end
      default: begin
        state_next = PIC_IDLE;
      end
    endcase
  end

  // Handshake state and in-service storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PIC_IDLE;
      inService_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      inService_reg <= inService_next;
    end
  end

  // vector and level presented to the core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqReq <= 1'b0;
      irqIdx_reg <= 4'h0;
      irqVector <= `PIC_VEC_PIN;
      irqLevel <= 2'h0;
    end else begin
      irqReq <= (state_next == PIC_REQ);
      if (state_next == PIC_REQ && !(state_reg == PIC_REQ && irqAck)) begin
        irqIdx_reg <= winIdx;
        irqVector <= vectorAddr(winIdx);
        irqLevel <= winLevel;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------

  // Address decode for reads; unmapped addresses read zero
  always_comb begin
    sfrRdata_next = 8'h00;
    if (sfrReq.addr == `PIC_ADDR_SELECT) begin
      sfrRdata_next = select_reg;
    end else if (sfrReq.addr == `PIC_ADDR_EN_PRI) begin
      sfrRdata_next = enPri_reg;
    end else if (sfrReq.addr == `PIC_ADDR_PRIO_LO) begin
      sfrRdata_next = prioLo_reg;
    end else if (sfrReq.addr == `PIC_ADDR_EN_SEC) begin
      sfrRdata_next = enSec_reg;
    end else if (sfrReq.addr == `PIC_ADDR_PRIO_HI) begin
      sfrRdata_next = prioHi_reg;
    end else if (sfrReq.addr == `PIC_ADDR_FLAGS) begin
      sfrRdata_next = flags_reg;
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else if (sfrReq.rd) begin
      sfrRdata <= sfrRdata_next;
    end
  end

endmodule : pic_top

/* File: pic_top_props.sv */
// Port-level property checker for the interrupt controller, bound to pic_top
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_top_props
  import pic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pic_pkg::pic_sfr_req_s sfrReq,
  input wire logic [7:0] sfrRdata,
  input wire pic_pkg::pic_src_s src,
  input wire pic_pkg::pic_wake_s wake,
  input wire logic irqAck,
  input wire logic retiPulse,
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  input wire logic [1:0] irqLevel
);
  logic gateReg;
  logic [7:0] loReg;
  logic [7:0] hiReg;
  logic actValid;
  logic [1:0] actLvl;
  logic [2:0] grp;

  // Group of the presented vector; both vector halves repeat the group order
  assign grp = irqVector[5:3];

  // Shadow copies of the global gate and the priority registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gateReg <= 1'b0;
      loReg <= 8'h00;
      hiReg <= 8'h00;
    end else if (sfrReq.wr) begin
      if (sfrReq.addr == `PIC_ADDR_EN_PRI) gateReg <= sfrReq.wdata[7];
      if (sfrReq.addr == `PIC_ADDR_PRIO_LO) loReg <= sfrReq.wdata & 8'h3f;
      if (sfrReq.addr == `PIC_ADDR_PRIO_HI) hiReg <= sfrReq.wdata & 8'h3f;
    end
  end

  // Level of the handler most recently entered; dropped on a return unless an entry comes in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      actValid <= 1'b0;
      actLvl <= 2'h0;
    end else if (irqReq && irqAck) begin
      actValid <= 1'b1;
      actLvl <= irqLevel;
    end else if (retiPulse) begin
      actValid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_global_gate: assert property (
    !gateReg && !$past(gateReg) |-> !irqReq) else $error("request while gate closed");
  chk_ack_release: assert property (
    irqReq && irqAck |=> !irqReq) else $error("request held after ack");
  chk_level_match: assert property (
    irqReq && $stable(loReg) && $stable(hiReg) |-> irqLevel == {hiReg[grp], loReg[grp]})
    else $error("presented level differs from group level");
  chk_only_higher: assert property (
    actValid && irqReq |-> irqLevel > actLvl) else $error("request not above active level");
  chk_timer_cause: assert property (
    irqReq && irqVector == 16'h000b |-> $past(src.firstTimerOverflow))
    else $error("timer vector without timer request");
  chk_pin_cause: assert property (
    irqReq && irqVector == 16'h0003 |-> $past(src.gpPinInputN) != 3'b111)
    else $error("pin vector without low pin");
  chk_rdata_hold: assert property (
    !sfrReq.rd |=> $stable(sfrRdata)) else $error("read data changed without read");
  chk_unmapped_zero: assert property (
    sfrReq.rd && !(sfrReq.addr inside {8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hc0})
    |=> sfrRdata == 8'h00) else $error("unmapped read not zero");
  chk_unused_bits: assert property (
    sfrReq.rd && sfrReq.addr inside {8'ha6, 8'ha9, 8'hb9} |=> sfrRdata[7:6] == 2'b00)
    else $error("unused bits read nonzero");
endmodule : pic_top_props

bind pic_top pic_top_props chk (.clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
  .src(src), .wake(wake), .irqAck(irqAck), .retiPulse(retiPulse), .irqReq(irqReq),
  .irqVector(irqVector), .irqLevel(irqLevel));

/* File: pic_core_model.sv */
// Behavioural core that acknowledges presented interrupt requests
`timescale 1ns/1ps
module pic_core_model (
  input wire logic clk,
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  output logic irqAck,
  output logic [15:0] lastVec
);
  logic [3:0] waitCnt;

  initial begin
    irqAck = 1'b0;
    lastVec = 16'h0000;
    waitCnt = 4'h0;
  end

  // Ack after a programmable wait, one cycle wide, off the falling edge
  always @(negedge clk) begin
    irqAck <= 1'b0;
    if (!irqReq || !ackEn || irqAck) begin
      waitCnt <= 4'h0;
    end else if (waitCnt == ackDelay) begin
      irqAck <= 1'b1;
      lastVec <= irqVector;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : pic_core_model

/* File: pic_top_tb_top.sv */
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_top_tb_top;
  import pic_pkg::*;
  localparam logic [7:0] ADR [6] = '{8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hc0};
  localparam logic [7:0] MSK [5] = '{8'h3f, 8'hbf, 8'h3f, 8'hbf, 8'h3f};
  localparam logic [15:0] VEC [18] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
    16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h0023,
    16'h002b, 16'h0053, 16'h0053, 16'h0063, 16'h0063};
  logic clk;
  logic rst;
  pic_sfr_req_s sfrReq;
  logic [7:0] sfrRdata;
  pic_src_s src;
  pic_wake_s wake;
  logic irqAck;
  logic retiPulse;
  logic irqReq;
  logic [15:0] irqVector;
  logic [1:0] irqLevel;
  logic ackEn;
  logic [3:0] ackDelay;
  logic [15:0] lastVec;
  logic [7:0] rdv;
  int num_errors;
  int checks;

  pic_top dut (.clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .src(src),
    .wake(wake), .irqAck(irqAck), .retiPulse(retiPulse), .irqReq(irqReq),
    .irqVector(irqVector), .irqLevel(irqLevel));
  pic_core_model core (.clk(clk), .ackEn(ackEn), .ackDelay(ackDelay), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .lastVec(lastVec));

  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    sfrReq.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfrReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    sfrReq.rd = 1'b0;
    rdv = sfrRdata;
  endtask : rd

  task automatic reti;
    @(negedge clk);
    retiPulse = 1'b1;
    @(negedge clk);
    retiPulse = 1'b0;
  endtask : reti

  // Waits a bounded time for the core to enter a handler, then checks the vector
  task automatic take(input string nm, input logic [15:0] exp);
    for (int i = 0; i < 60 && irqAck !== 1'b1; i++) @(posedge clk);
    if (irqAck !== 1'b1) begin
      cmp({nm, " timeout"}, 16'h0001, 16'h0000);
      wrap_up();
    end
    cmp(nm, exp, lastVec);
    @(negedge clk);
  endtask : take

  task automatic quiet(input string nm);
    repeat (8) @(negedge clk);
    cmp(nm, 16'h0000, {15'h0000, irqReq});
  endtask : quiet

  // Sets one request source active or idle
  task automatic drive(input int k, input logic v);
    case (k)
      0: src.gpPinInputN[1] = !v;
      1: src.firstTimerOverflow = v;
      2: src.powerFailRequestN = !v;
      3: src.secondTimerOverflow = v;
      4: src.serialReceiveRequest = v;
      5: src.thirdTimerReload = v;
      6: src.radioSerialReady = v;
      7: src.radioRequest = v;
      8: src.masterSerialDone = v;
      9: src.wakeOnPinRequest = v;
      10: src.randomReadyRequest = v;
      11: src.wakeTimerTick = v;
      12: src.serialTransmitRequest = v;
      13: src.thirdTimerOverflow = v;
      14: src.twoWireDone = v;
      15: src.slaveSerialDone = v;
      16: src.crystalStartedRequest = v;
      default: src.converterReadyRequest = v;
    endcase
  endtask : drive

  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      rd(ADR[i]);
      cmp("reset value", {8'h00, i == 0 ? 8'h01 : 8'h00}, {8'h00, rdv});
    end
    for (int i = 0; i < 5; i++) begin
      wr(ADR[i], 8'hff);
      rd(ADR[i]);
      cmp("write mask", {8'h00, MSK[i]}, {8'h00, rdv});
    end
    wr(8'ha7, 8'hff);
    rd(8'ha7);
    cmp("unmapped", 16'h0000, {8'h00, rdv});
    wr(8'ha6, 8'h17);
    wr(8'ha9, 8'h00);
    wr(8'hb9, 8'h00);
  endtask : t_regs

  task automatic t_vectors;
    for (int k = 0; k < 18; k++) begin
      ackDelay = 4'(k % 4);
      drive(k, 1'b1);
      ackEn = 1'b1;
      take("vector", VEC[k]);
      ackEn = 1'b0;
      drive(k, 1'b0);
      rd(8'hc0);
      cmp("flag clear", {8'h00, k == 5 ? 8'h80 : k == 13 ? 8'h40 : 8'h00},
        {8'h00, rdv & 8'hf8});
      wr(8'hc0, 8'h00);
      reti();
      quiet("idle after return");
    end
  endtask : t_vectors

  task automatic t_gating;
    wr(8'ha8, 8'h3f);
    drive(1, 1'b1);
    quiet("gate closed");
    ackEn = 1'b1;
    wr(8'ha8, 8'hbf);
    take("gate open", 16'h000b);
    ackEn = 1'b0;
    drive(1, 1'b0);
    reti();
    wake.radioEn = 1'b0;
    src.gpPinInputN[0] = 1'b0;
    drive(7, 1'b1);
    quiet("masked sources");
    rd(8'hc0);
    cmp("masked flags", 16'h0000, {8'h00, rdv});
    drive(7, 1'b0);
    src.gpPinInputN[0] = 1'b1;
    repeat (4) @(negedge clk);
    wake.radioEn = 1'b1;
    ackEn = 1'b1;
    wake.pinPolarity = 1'b1;
    take("inverted wake pin", 16'h005b);
    ackEn = 1'b0;
    wake.pinPolarity = 1'b0;
    reti();
  endtask : t_gating

  task automatic t_prio;
    ackDelay = 4'h0;
    wr(8'ha9, 8'h20);
    wr(8'hb9, 8'h20);
    drive(0, 1'b1);
    drive(1, 1'b1);
    drive(11, 1'b1);
    repeat (3) @(negedge clk);
    ackEn = 1'b1;
    take("highest level", 16'h006b);
    cmp("presented level", 16'h0003, {14'h0000, irqLevel});
    ackEn = 1'b0;
    drive(11, 1'b0);
    rd(8'hc0);
    cmp("tick flag", 16'h0000, {8'h00, rdv & 8'h20});
    quiet("lower level held");
    reti();
    ackEn = 1'b1;
    take("tie lowest vector", 16'h0003);
    ackEn = 1'b0;
    drive(0, 1'b0);
    quiet("equal level held");
    ackEn = 1'b1;
    drive(11, 1'b1);
    take("preempt", 16'h006b);
    drive(11, 1'b0);
    reti();
    reti();
    take("after returns", 16'h000b);
    ackEn = 1'b0;
    drive(1, 1'b0);
    reti();
  endtask : t_prio

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    sfrReq = '0;
    src = '0;
    src.powerFailRequestN = 1'b1;
    src.gpPinInputN = 3'b111;
    wake = '{radioEn: 1'b1, pinEn: 1'b1, miscEn: 1'b1, tickEn: 1'b1, pinPolarity: 1'b0};
    retiPulse = 1'b0;
    ackEn = 1'b0;
    ackDelay = 4'h0;
    num_errors = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_vectors();
    t_gating();
    t_prio();
    wrap_up();
  end
endmodule : pic_top_tb_top
